// *** design/flash_status_cfg.svh ***
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// Register byte offsets
`define OFF_STATUS      8'h08
`define OFF_FUSE_HIGH   8'h0C
`define OFF_FUSE_LOW    8'h10
`define OFF_FUSE_CTRL   8'h14

// Status word field positions
`define BIT_READY       0
`define BIT_LOCK_ERR    2
`define BIT_PROG_ERR    3
`define BIT_SECURITY    4
`define BIT_BLANK       5
`define FSZ_LSB         13
`define FSZ_MSB         15
`define LOCK_LSB        16
`define LOCK_MSB        31

// Fuse control word
`define BIT_FREEZE      0
`define FREEZE_RESET    1'b0

// Command word checks
`define CMD_KEY         8'hA5
`define CMD_LAST_CODE   6'h0F

// Defaults
`define FSZ_DEFAULT     3'h5
`define FUSE_COUNT_DEF  32
`define STATUS_RESET    32'h0000_0000

`endif

// *** design/flash_status_pkg.sv ***
package flash_status_pkg;

  typedef struct packed {
    logic        lock_err;
    logic        prog_err;
    logic        blank_res;
    logic        freeze;
    logic [1:0]  reported;
    logic        err_resp;
    logic [31:0] rdata;
  } status_s;

  typedef struct packed {
    logic [63:0] bits;
  } fuse_s;

endpackage

// *** design/fuse_mirror.sv ***
`include "flash_status_cfg.svh"

module fuse_mirror #(
  parameter int FUSE_COUNT = `FUSE_COUNT_DEF
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        freeze,
  input  wire logic [63:0] fuse_raw,
  output logic      [31:0] fuse_low,
  output logic      [31:0] fuse_high
);

  flash_status_pkg::fuse_s cur_reg;
  flash_status_pkg::fuse_s cur_next;
  logic [63:0]             implemented;

  // Unbacked fuse positions are forced low
  for (genvar i = 0; i < 64; i++) begin : g_fuse
    assign implemented[i] = (i < FUSE_COUNT);
  end

  always_comb begin
    cur_next = cur_reg;
    // Freeze lets software read a coherent snapshot of both words
    if (!freeze) begin
      cur_next.bits = fuse_raw & implemented;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg <= '0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign fuse_low  = cur_reg.bits[31:0];
  assign fuse_high = cur_reg.bits[63:32];

  chk_high_unused: assert property (@(posedge pclk) disable iff (!presetn)
    (FUSE_COUNT <= 32) |-> fuse_high == 32'h0000_0000)
    else $error("high fuse word not zero without upper fuses");

endmodule

// *** design/flash_status_fuse_readout.sv ***
// Implementation choice: the APB slave port.
`include "flash_status_cfg.svh"

module flash_status_fuse_readout #(
  parameter int       ADDR_W     = 8,
  parameter int       FUSE_COUNT = `FUSE_COUNT_DEF,
  parameter bit [2:0] FSZ_CODE   = `FSZ_DEFAULT
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              cmd_busy,
  input  wire logic              cmd_write,
  input  wire logic [7:0]        cmd_key,
  input  wire logic [5:0]        cmd_code,
  output logic                   cmd_accept,
  input  wire logic              lock_hit,
  input  wire logic              security_active,
  input  wire logic              blank_done,
  input  wire logic              blank_erased,
  input  wire logic [15:0]       region_lock,
  input  wire logic [63:0]       fuse_raw
);

  flash_status_pkg::status_s cur_reg;
  flash_status_pkg::status_s cur_next;

  logic        setup;
  logic        access;
  logic [7:0]  addr;
  logic        hit_status;
  logic        hit_high;
  logic        hit_low;
  logic        hit_ctrl;
  logic        key_ok;
  logic        code_ok;
  logic        lock_set;
  logic        prog_set;
  logic        status_clr;
  logic [31:0] status_word;
  logic [31:0] fuse_low;
  logic [31:0] fuse_high;

  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign addr   = 8'(paddr);

  assign hit_status = (addr == `OFF_STATUS);
  assign hit_high   = (addr == `OFF_FUSE_HIGH);
  assign hit_low    = (addr == `OFF_FUSE_LOW);
  assign hit_ctrl   = (addr == `OFF_FUSE_CTRL);

  // Command word screening
  assign key_ok  = (cmd_key == `CMD_KEY);
  assign code_ok = (cmd_code <= `CMD_LAST_CODE);
  // A command landing while busy is refused too
  assign cmd_accept = cmd_write & key_ok & code_ok & ~cmd_busy;

  assign lock_set = lock_hit;
  assign prog_set = cmd_write & (~key_ok | ~code_ok | cmd_busy);

  // Clear happens at the completing edge of a status read
  assign status_clr = access & ~pwrite & hit_status;

  fuse_mirror #(
    .FUSE_COUNT (FUSE_COUNT)
  ) u_fuse (
    .pclk      (pclk),
    .presetn   (presetn),
    .freeze    (cur_reg.freeze),
    .fuse_raw  (fuse_raw),
    .fuse_low  (fuse_low),
    .fuse_high (fuse_high)
  );

  always_comb begin
    status_word = `STATUS_RESET;
    status_word[`BIT_READY]    = ~cmd_busy;
    status_word[`BIT_LOCK_ERR] = cur_reg.lock_err;
    status_word[`BIT_PROG_ERR] = cur_reg.prog_err;
    status_word[`BIT_SECURITY] = security_active;
    status_word[`BIT_BLANK]    = cur_reg.blank_res;
    status_word[`FSZ_MSB:`FSZ_LSB]   = FSZ_CODE;
    status_word[`LOCK_MSB:`LOCK_LSB] = region_lock;
  end

  always_comb begin
    cur_next = cur_reg;

    // Read data is latched in the setup cycle and shown in the access cycle
    if (setup) begin
      cur_next.rdata    = 32'h0000_0000;
      cur_next.reported = 2'b00;
      cur_next.err_resp = 1'b0;
      if (hit_status) begin
        if (!pwrite) begin
          cur_next.rdata    = status_word;
          cur_next.reported = {cur_reg.prog_err, cur_reg.lock_err};
        end
      end else if (hit_high) begin
        if (!pwrite) begin
          cur_next.rdata = fuse_high;
        end
      end else if (hit_low) begin
        if (!pwrite) begin
          cur_next.rdata = fuse_low;
        end
      end else if (hit_ctrl) begin
        if (!pwrite) begin
          cur_next.rdata[`BIT_FREEZE] = cur_reg.freeze;
        end
      end else begin
        cur_next.err_resp = 1'b1;
      end
    end

    // Only the flag values actually returned are cleared; a new event wins
    cur_next.lock_err = lock_set |
      (cur_reg.lock_err & ~(status_clr & cur_reg.reported[0]));
    cur_next.prog_err = prog_set |
      (cur_reg.prog_err & ~(status_clr & cur_reg.reported[1]));

    if (blank_done) begin
      cur_next.blank_res = blank_erased;
    end

    // Status and fuse words take no write; only the control word does
    if (access && pwrite && hit_ctrl) begin
      cur_next.freeze = pwdata[`BIT_FREEZE];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_reg.lock_err  <= 1'b0;
      cur_reg.prog_err  <= 1'b0;
      cur_reg.blank_res <= 1'b0;
      cur_reg.freeze    <= `FREEZE_RESET;
      cur_reg.reported  <= 2'b00;
      cur_reg.err_resp  <= 1'b0;
      cur_reg.rdata     <= 32'h0000_0000;
    end else begin
      cur_reg <= cur_next;
    end
  end

  // Fixed one wait-free access: answer in the first access cycle
  assign pready  = access;
  assign pslverr = access & cur_reg.err_resp;
  assign prdata  = cur_reg.rdata;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_ready_tracks_busy: assert property (
    (setup && !pwrite && hit_status) |=> prdata[`BIT_READY] == !$past(cmd_busy))
    else $error("ready flag does not mirror busy");

  chk_lock_err_set: assert property (
    lock_hit |=> cur_reg.lock_err)
    else $error("lock violation flag not set");

  chk_lock_err_holds: assert property (
    (cur_reg.lock_err && !status_clr) |=> cur_reg.lock_err)
    else $error("lock violation flag dropped without a read");

  chk_prog_bad_key: assert property (
    (cmd_write && cmd_key != `CMD_KEY) |=> cur_reg.prog_err && !$past(cmd_accept))
    else $error("bad key not flagged");

  chk_prog_bad_code: assert property (
    (cmd_write && cmd_code > `CMD_LAST_CODE) |=> cur_reg.prog_err)
    else $error("bad command code not flagged");

  chk_read_clears: assert property (
    (setup && !pwrite && hit_status && cur_reg.lock_err && cur_reg.prog_err)
      ##1 (access && !lock_hit && !prog_set)
      |=> !cur_reg.lock_err && !cur_reg.prog_err)
    else $error("status read did not clear error flags");

  chk_read_returns: assert property (
    (setup && !pwrite && hit_status) |=>
      prdata[`BIT_LOCK_ERR] == $past(cur_reg.lock_err) &&
      prdata[`BIT_PROG_ERR] == $past(cur_reg.prog_err))
    else $error("status read returned wrong flags");

  chk_security_bit: assert property (
    (setup && !pwrite && hit_status) |=>
      prdata[`BIT_SECURITY] == $past(security_active))
    else $error("security bit wrong");

  chk_blank_result: assert property (
    blank_done |=> cur_reg.blank_res == $past(blank_erased))
    else $error("blank-check result not captured");

  chk_size_code: assert property (
    (setup && !pwrite && hit_status) |=> prdata[`FSZ_MSB:`FSZ_LSB] == FSZ_CODE)
    else $error("flash size code wrong");

  chk_region_locks: assert property (
    (setup && !pwrite && hit_status) |=>
      prdata[`LOCK_MSB:`LOCK_LSB] == $past(region_lock))
    else $error("region lock bits wrong");

  chk_fuse_low_read: assert property (
    (setup && !pwrite && hit_low) |=> prdata == $past(fuse_low))
    else $error("low fuse word read wrong");

  chk_reserved_zero: assert property (
    (setup && !pwrite && hit_status) |=> prdata[12:6] == 7'h00 && prdata[1] == 1'b0)
    else $error("reserved status bits not zero");

  chk_write_ignored: assert property (
    (access && pwrite && (hit_status || hit_low || hit_high) && !blank_done)
      |=> $stable(cur_reg.blank_res) && $stable(cur_reg.freeze))
    else $error("write to read-only word had an effect");

  chk_fuse_high_read: assert property (
    (setup && !pwrite && hit_high) |=> prdata == $past(fuse_high))
    else $error("high fuse word read wrong");

  chk_ctrl_read_back: assert property (
    (setup && !pwrite && hit_ctrl) |=> prdata == {31'h0000_0000, $past(cur_reg.freeze)})
    else $error("fuse control read wrong");

  chk_unmapped_error: assert property (
    (setup && !hit_status && !hit_high && !hit_low && !hit_ctrl)
      |=> cur_reg.err_resp && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");

  chk_mapped_no_error: assert property (
    (setup && (hit_status || hit_high || hit_low || hit_ctrl)) |=> !cur_reg.err_resp)
    else $error("mapped access refused");

  chk_write_data_zero: assert property (
    (setup && pwrite) |=> prdata == 32'h0000_0000)
    else $error("write returned read data");

  chk_prog_while_busy: assert property (
    (cmd_write && cmd_busy) |=> cur_reg.prog_err)
    else $error("command while busy not flagged");

  chk_accept_good_cmd: assert property (
    (cmd_write && cmd_key == `CMD_KEY && cmd_code <= `CMD_LAST_CODE && !cmd_busy)
      |-> cmd_accept)
    else $error("valid command not accepted");

  chk_accept_bad_key: assert property (
    (cmd_key != `CMD_KEY) |-> !cmd_accept)
    else $error("command accepted with wrong key");

  chk_accept_bad_code: assert property (
    (cmd_code > `CMD_LAST_CODE) |-> !cmd_accept)
    else $error("unsupported command accepted");

  chk_accept_busy: assert property (
    cmd_busy |-> !cmd_accept)
    else $error("command accepted while busy");

  chk_prog_err_holds: assert property (
    (cur_reg.prog_err && !status_clr) |=> cur_reg.prog_err)
    else $error("program error flag dropped without a read");

  chk_lock_no_spurious: assert property (
    (!lock_hit && !cur_reg.lock_err) |=> !cur_reg.lock_err)
    else $error("lock violation flag set without an event");

  chk_prog_no_spurious: assert property (
    (!prog_set && !cur_reg.prog_err) |=> !cur_reg.prog_err)
    else $error("program error flag set without an event");

  chk_blank_holds: assert property (
    !blank_done |=> $stable(cur_reg.blank_res))
    else $error("blank-check result changed without a check");

  chk_blank_read: assert property (
    (setup && !pwrite && hit_status) |=>
      prdata[`BIT_BLANK] == $past(cur_reg.blank_res))
    else $error("blank-check bit read wrong");

  chk_freeze_write_only: assert property (
    (access && pwrite && !hit_ctrl) |=> $stable(cur_reg.freeze))
    else $error("fuse control changed by another write");

  chk_reported_latch: assert property (
    (setup && !pwrite && hit_status) |=>
      cur_reg.reported == {$past(cur_reg.prog_err), $past(cur_reg.lock_err)})
    else $error("returned flag copy wrong");

  chk_lock_keep_unread: assert property (
    (status_clr && !cur_reg.reported[0] && cur_reg.lock_err) |=> cur_reg.lock_err)
    else $error("unreturned lock violation cleared");

  chk_prog_keep_unread: assert property (
    (status_clr && !cur_reg.reported[1] && cur_reg.prog_err) |=> cur_reg.prog_err)
    else $error("unreturned program error cleared");

  chk_lock_beats_clear: assert property (
    (status_clr && lock_hit) |=> cur_reg.lock_err)
    else $error("lock event lost against clear");

  chk_prog_beats_clear: assert property (
    (status_clr && prog_set) |=> cur_reg.prog_err)
    else $error("program error event lost against clear");

  chk_rdata_holds: assert property (
    !setup |=> $stable(prdata))
    else $error("read data changed outside a setup cycle");

  chk_fuse_frozen: assert property (
    cur_reg.freeze |=> $stable(fuse_low) && $stable(fuse_high))
    else $error("fuse words moved while frozen");

  chk_fuse_high_masked: assert property (
    (FUSE_COUNT > 32 && FUSE_COUNT < 64) |->
      (fuse_high >> (FUSE_COUNT - 32)) == 32'h0000_0000)
    else $error("unbacked high fuse bits not zero");

  chk_ready_while_busy: assert property (
    (setup && !pwrite && hit_status && cmd_busy) |=> !prdata[`BIT_READY])
    else $error("ready flag high while busy");

  chk_no_err_idle: assert property (
    !access |-> !pslverr)
    else $error("error response outside access");

  chk_read_lock_set: assert property (
    (setup && !pwrite && hit_status && cur_reg.lock_err) |=> prdata[`BIT_LOCK_ERR])
    else $error("set lock violation flag not returned");

endmodule

// *** testbench/flash_status_fuse_readout_tb.sv ***
module flash_status_fuse_readout_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int       FUSES = 40;
  localparam bit [2:0] FLASH_SIZE_CODE   = 3'h6;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, cmd_accept;
  logic [7:0]  paddr, cmd_key;
  logic [31:0] pwdata, prdata;
  logic        cmd_busy, cmd_write, lock_hit, security_active, blank_done, blank_erased;
  logic [5:0]  cmd_code;
  logic [15:0] region_lock;
  logic [63:0] fuse_raw;
  logic        blank_m;
  logic [32:0] exp_q[$];
  int          bad_count, num_checks;

  flash_status_fuse_readout #(.ADDR_W(8), .FUSE_COUNT(FUSES), .FSZ_CODE(FLASH_SIZE_CODE)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmd_busy(cmd_busy), .cmd_write(cmd_write), .cmd_key(cmd_key), .cmd_code(cmd_code),
    .cmd_accept(cmd_accept), .lock_hit(lock_hit), .security_active(security_active),
    .blank_done(blank_done), .blank_erased(blank_erased), .region_lock(region_lock),
    .fuse_raw(fuse_raw));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic cmp(input logic [32:0] e, input logic [32:0] g);
    num_checks++;
    if (g !== e) begin
      bad_count++;
      $display("mismatch at %0t exp %h got %h", $time, e, g);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // Monitor takes the oldest expectation at each completed access
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1) begin
      if (exp_q.size() == 0) cmp(33'h0, {pslverr, prdata});
      else cmp(exp_q.pop_front(), {pslverr, prdata});
    end
  end

  function automatic logic [31:0] st(input logic l, input logic p);
    st = {region_lock, FLASH_SIZE_CODE, 7'h00, blank_m, security_active, p, l, 1'b0, ~cmd_busy};
  endfunction

  function automatic logic [31:0] hi_exp();
    hi_exp = fuse_raw[63:32] & ((32'h1 << (FUSES - 32)) - 32'h1);
  endfunction

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
                     input logic [32:0] e);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    exp_q.push_back(e);
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      bad_count++;
      close_out();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0, {1'b0, e});
  endtask

  // Pulse one command write; acceptance is combinational, looked at mid-cycle
  task automatic cmd(input logic [7:0] k, input logic [5:0] c, input logic ok);
    @(posedge pclk);
    cmd_write <= 1'b1;
    cmd_key <= k;
    cmd_code <= c;
    @(negedge pclk);
    cmp({32'h0, ok}, {32'h0, cmd_accept});
    @(posedge pclk);
    cmd_write <= 1'b0;
  endtask

  task automatic pulse_lock();
    @(posedge pclk);
    lock_hit <= 1'b1;
    @(posedge pclk);
    lock_hit <= 1'b0;
  endtask

  initial begin
    logic [7:0] k;
    logic ok;
    {psel, penable, pwrite, paddr, pwdata, cmd_busy, cmd_write, cmd_key, cmd_code} = '0;
    {lock_hit, security_active, blank_done, blank_erased, blank_m} = '0;
    bad_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    void'($urandom(32'h5bcd98f5));
    region_lock = 16'($urandom);
    fuse_raw = {$urandom, $urandom};
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd(8'h08, st(1'b0, 1'b0));
    rd(8'h10, fuse_raw[31:0]);
    rd(8'h0C, hi_exp());
    rd(8'h14, 32'h0);
    $display("test reset done");
    region_lock <= 16'($urandom);
    pulse_lock();
    apb(8'h08, 1'b1, 32'hFFFFFFFF, 33'h0);
    apb(8'h10, 1'b1, 32'h0, 33'h0);
    rd(8'h08, st(1'b1, 1'b0));
    rd(8'h08, st(1'b0, 1'b0));
    rd(8'h10, fuse_raw[31:0]);
    $display("test lock flag done");
    for (int i = 0; i < 19; i++) begin
      k = (i == 17) ? 8'($urandom) : 8'hA5;
      if (i == 17 && k == 8'hA5) k = 8'h5A;
      cmd_busy <= (i == 18);
      ok = (i <= 15);
      cmd(k, (i > 16) ? 6'($urandom % 16) : 6'(i), ok);
      rd(8'h08, st(1'b0, ~ok));
    end
    cmd_busy <= 1'b0;
    $display("test commands done");
    security_active <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      @(posedge pclk);
      blank_done <= 1'b1;
      blank_erased <= (i == 0);
      @(posedge pclk);
      blank_done <= 1'b0;
      blank_erased <= (i != 0);
      blank_m = (i == 0);
      rd(8'h08, st(1'b0, 1'b0));
    end
    security_active <= 1'b0;
    @(posedge pclk);
    rd(8'h08, st(1'b0, 1'b0));
    $display("test security blank done");
    apb(8'h14, 1'b1, 32'h1, 33'h0);
    rd(8'h14, 32'h1);
    k = 8'($urandom);
    fuse_raw <= ~fuse_raw;
    rd(8'h10, fuse_raw[31:0]);
    apb(8'h14, 1'b1, 32'h0, 33'h0);
    repeat (2) @(posedge pclk);
    rd(8'h10, fuse_raw[31:0]);
    rd(8'h0C, hi_exp());
    $display("test freeze done");
    apb(8'h20, 1'b0, 32'h0, {1'b1, 32'h0});
    apb(8'h24, 1'b1, 32'($urandom), {1'b1, 32'h0});
    $display("test unmapped done");
    repeat (2) @(posedge pclk);
    close_out();
  end
endmodule
